/* File: verilog/tcc_core.sv */
// Purpose: counter control of a general-purpose timer
// Assumes: register port strobes are one cycle, never together
// Notes:   counter, prescaler and compare values are 16 bits
// Function
// R1: software sets run enable before counting in external, gated, encoder modes.
// R2: trigger mode lets hardware set run enable without software.
// R3: update loads buffered reload, prescaler and compare values into active ones.
// R4: update disable low: overflow, underflow, generate bit, slave request cause update.
// R5: update disable high: no update event from any source.
// R6: source select high: only overflow or underflow give update.
// R7: one-shot clears run enable at the next update event.
// R8: direction 0 up, 1 down; read-only in center or encoder operation.
// R9: alignment 00 edge-aligned; other codes count up and down alternately.
// R10: center codes 01 down, 10 up, 11 both set compare flags.
// R11: software changes alignment only while run enable is zero.
// R12: buffered reload waits for update; unbuffered reload acts at once.
// R13: control bits 31 to 8 read zero, writes ignored.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module tcc_core
    import tcc_pkg::*;
(
    input  wire logic              ref_clk,     // kernel clock
    input  wire logic              rst,         // async reset
    input  wire logic              ce,          // clock enable
    input  wire logic [7:0]        addr,        // byte address
    input  wire logic [31:0]       wrData,      // write data
    input  wire logic              wrStb,       // write strobe
    input  wire logic              rdStb,       // read strobe
    output logic      [31:0]       rdData,      // read data
    input  wire logic              trigStart,   // trigger-mode start
    input  wire logic              slaveUpdReq, // slave update request
    input  wire logic              encMode,     // encoder operation
    input  wire logic              encDir,      // encoder direction
    output logic                   updateEventPulse, // update pulse
    output logic                   cntDown,     // counting down
    output logic                   cntRunning,  // run enable state
    output logic      [TCC_VW-1:0] cntValue,    // counter value
    output logic      [TCC_VW-1:0] reloadValue, // active reload
    output logic      [TCC_VW-1:0] pscValue,    // active prescaler
    output logic      [TCC_VW-1:0] cmpValue0,   // active compare 0
    output logic      [TCC_VW-1:0] cmpValue1,   // active compare 1
    output logic      [TCC_VW-1:0] cmpValue2,   // active compare 2
    output logic      [TCC_VW-1:0] cmpValue3,   // active compare 3
    output logic                   irq          // interrupt level
);
    // control register fields
    logic                   runEn_r;
    logic                   updDis_r;
    logic                   updSrc_r;
    logic                   oneShot_r;
    logic                   dir_r;
    tcc_aln_t               aln_r;
    logic                   arBuf_r;
    // counter state
    logic [TCC_VW-1:0]      cnt_r;
    logic [TCC_VW-1:0]      pscCnt_r;
    logic [TCC_STAT_W-1:0]  stat_r;
    logic [TCC_STAT_W-1:0]  mask_r;
    logic [TCC_STAT_W-1:0]  statSet;
    logic [TCC_CTRL_W-1:0]  ctrlView;
    logic [TCC_VW-1:0]      arrBuf;
    logic [TCC_VW-1:0]      pscBuf;
    logic [TCC_VW-1:0]      cmpBuf [TCC_NCH];
    logic [TCC_VW-1:0]      cmpAct [TCC_NCH];
    logic                   ctrlWr;
    logic                   ugWr;
    logic                   swReq;
    logic                   tick;
    logic                   wrap;
    logic                   updEvt;
    logic                   center;
    logic                   dirLocked;

    // offset match helper
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // compare register offset of a channel
    function automatic logic [7:0] cmpOfs(input int ch);
        cmpOfs = TCC_OFS_CMP0 + 8'(ch * 4);
    endfunction

    // decode of writes
    assign ctrlWr = wrStb && hit(addr, TCC_OFS_CTRL);
    assign ugWr   = wrStb && hit(addr, TCC_OFS_EVGEN)
                    && wrData[TCC_G_UPD];
    assign center = (aln_r != TCC_ALN_EDGE);      // [R9]
    assign dirLocked = center || encMode;          // [R8]

    // software or slave requests qualify only when source select is low
    assign swReq = !updSrc_r && (ugWr || slaveUpdReq); // [R6]
    // update event: wrap or qualified requests, none when disabled
    assign updEvt = !updDis_r && (wrap || swReq); // [R4] [R5]
    assign updateEventPulse = ce && updEvt;

    // prescaler tick when running
    assign tick = runEn_r && (pscCnt_r == pscValue);

    // overflow or underflow on this tick
    always_comb begin
        wrap = 1'b0;
        if (tick) begin
            if (!dir_r) begin
                wrap = (cnt_r == reloadValue);
            end else begin
                wrap = (cnt_r == TCC_VAL_RST);
            end
        end
    end

    // run enable: software write, trigger set, one-shot clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            runEn_r <= 1'b0;
        end else if (ce) begin
            if (trigStart) begin
                runEn_r <= 1'b1;                   // [R2]
            end else if (updEvt && oneShot_r) begin
                runEn_r <= 1'b0;                   // [R7]
            end else if (ctrlWr) begin
                runEn_r <= wrData[TCC_B_RUN];      // [R1]
            end
        end
    end

    // plain control fields
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            updDis_r  <= TCC_CTRL_RST[TCC_B_UDIS];
            updSrc_r  <= TCC_CTRL_RST[TCC_B_USRC];
            oneShot_r <= TCC_CTRL_RST[TCC_B_ONE];
            aln_r     <= TCC_ALN_EDGE;
            arBuf_r   <= TCC_CTRL_RST[TCC_B_ARBUF];
        end else if (ce && ctrlWr) begin
            updDis_r  <= wrData[TCC_B_UDIS];
            updSrc_r  <= wrData[TCC_B_USRC];
            oneShot_r <= wrData[TCC_B_ONE];
            // alignment taken as written; change it only when stopped
            aln_r     <= tcc_aln_t'(wrData[TCC_B_ALN +: 2]); // [R11]
            arBuf_r   <= wrData[TCC_B_ARBUF];
        end
    end

    // direction: software owned in edge mode outside encoder operation, hardware otherwise
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dir_r <= TCC_CTRL_RST[TCC_B_DIR];
        end else if (ce) begin
            if (encMode) begin
                dir_r <= encDir;                   // [R8]
            end else if (center) begin
                if (tick && !dir_r
                    && cnt_r == reloadValue) begin
                    dir_r <= 1'b1;                 // [R9]
                end else if (tick && dir_r
                    && cnt_r == TCC_VAL_RST) begin
                    dir_r <= 1'b0;                 // [R9]
                end
            end else if (ctrlWr && !dirLocked) begin
                dir_r <= wrData[TCC_B_DIR];        // [R8]
            end
        end
    end

    // prescaler counter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pscCnt_r <= TCC_VAL_RST;
        end else if (ce) begin
            if (updEvt && swReq) begin
                pscCnt_r <= TCC_VAL_RST;
            end else if (tick) begin
                pscCnt_r <= TCC_VAL_RST;
            end else if (runEn_r) begin
                pscCnt_r <= pscCnt_r + 16'h0001;
            end
        end
    end

    // main counter, edge or center aligned
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= TCC_VAL_RST;
        end else if (ce) begin
            if (updEvt && swReq) begin
                // requested update restarts the count
                cnt_r <= dir_r ? reloadValue : TCC_VAL_RST;
            end else if (tick) begin
                if (center) begin                  // [R9]
                    if (!dir_r) begin
                        cnt_r <= wrap ? cnt_r - 16'h0001
                                      : cnt_r + 16'h0001;
                    end else begin
                        cnt_r <= wrap ? cnt_r + 16'h0001
                                      : cnt_r - 16'h0001;
                    end
                end else if (!dir_r) begin
                    cnt_r <= wrap ? TCC_VAL_RST
                                  : cnt_r + 16'h0001;
                end else begin
                    cnt_r <= wrap ? reloadValue
                                  : cnt_r - 16'h0001;
                end
            end
        end
    end

    // reload value, buffered as software chooses
    tcc_preload_reg uReload (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .wrEn    (wrStb && hit(addr, TCC_OFS_RELOAD)),
        .wrData  (wrData[TCC_VW-1:0]),
        .bufEn   (arBuf_r),                        // [R12]
        .load    (updEvt),                         // [R3]
        .bufVal  (arrBuf),
        .actVal  (reloadValue)
    );

    // prescaler value, always buffered
    tcc_preload_reg uPsc (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .wrEn    (wrStb && hit(addr, TCC_OFS_PSC)),
        .wrData  (wrData[TCC_VW-1:0]),
        .bufEn   (1'b1),
        .load    (updEvt),                         // [R3]
        .bufVal  (pscBuf),
        .actVal  (pscValue)
    );

    // channel compare values, always buffered
    for (genvar ch = 0; ch < TCC_NCH; ch++) begin : gCmp
        tcc_preload_reg uCmp (
            .ref_clk (ref_clk),
            .rst     (rst),
            .ce      (ce),
            .wrEn    (wrStb && hit(addr, cmpOfs(ch))),
            .wrData  (wrData[TCC_VW-1:0]),
            .bufEn   (1'b1),
            .load    (updEvt),                     // [R3]
            .bufVal  (cmpBuf[ch]),
            .actVal  (cmpAct[ch])
        );
    end

    assign cmpValue0 = cmpAct[0];
    assign cmpValue1 = cmpAct[1];
    assign cmpValue2 = cmpAct[2];
    assign cmpValue3 = cmpAct[3];

    // event sources of the sticky status bits
    always_comb begin
        statSet = '0;
        statSet[TCC_S_UPD] = updEvt;
        for (int ch = 0; ch < TCC_NCH; ch++) begin
            if (tick && cnt_r == cmpAct[ch]) begin
                case (aln_r)
                    TCC_ALN_EDGE: statSet[TCC_S_CMP + ch] = 1'b1;
                    TCC_ALN_DOWN: statSet[TCC_S_CMP + ch] = dir_r;  // [R10]
                    TCC_ALN_UP:   statSet[TCC_S_CMP + ch] = !dir_r; // [R10]
                    TCC_ALN_BOTH: statSet[TCC_S_CMP + ch] = 1'b1;   // [R10]
                    default:      statSet[TCC_S_CMP + ch] = 1'b0;
                endcase
            end
        end
    end

    // status: write one to clear, a new event wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stat_r <= TCC_STAT_RST;
        end else if (ce) begin
            if (wrStb && hit(addr, TCC_OFS_STAT)) begin
                stat_r <= (stat_r & ~wrData[TCC_STAT_W-1:0])
                          | statSet;
            end else begin
                stat_r <= stat_r | statSet;
            end
        end
    end

    // interrupt mask
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mask_r <= TCC_STAT_RST;
        end else if (ce && wrStb && hit(addr, TCC_OFS_MASK)) begin
            mask_r <= wrData[TCC_STAT_W-1:0];
        end
    end

    assign irq = |(stat_r & mask_r);

    // visible control word
    always_comb begin
        ctrlView = TCC_CTRL_RST;
        ctrlView[TCC_B_RUN]      = runEn_r;
        ctrlView[TCC_B_UDIS]     = updDis_r;
        ctrlView[TCC_B_USRC]     = updSrc_r;
        ctrlView[TCC_B_ONE]      = oneShot_r;
        ctrlView[TCC_B_DIR]      = dir_r;
        ctrlView[TCC_B_ALN +: 2] = aln_r;
        ctrlView[TCC_B_ARBUF]    = arBuf_r;
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdData <= '0;
        end else if (ce) begin
            rdData <= '0;
            if (rdStb) begin
                if (hit(addr, TCC_OFS_CTRL)) begin
                    rdData <= {24'h000000, ctrlView}; // [R13]
                end else if (hit(addr, TCC_OFS_RELOAD)) begin
                    rdData <= {16'h0000, arrBuf};
                end else if (hit(addr, TCC_OFS_PSC)) begin
                    rdData <= {16'h0000, pscBuf};
                end else if (hit(addr, TCC_OFS_CNT)) begin
                    rdData <= {16'h0000, cnt_r};
                end else if (hit(addr, TCC_OFS_STAT)) begin
                    rdData <= {27'h0000000, stat_r};
                end else if (hit(addr, TCC_OFS_MASK)) begin
                    rdData <= {27'h0000000, mask_r};
                end else begin
                    for (int ch = 0; ch < TCC_NCH; ch++) begin
                        if (hit(addr, cmpOfs(ch))) begin
                            rdData <= {16'h0000, cmpBuf[ch]};
                        end
                    end
                end
            end
        end
    end

    assign cntDown    = dir_r;
    assign cntRunning = runEn_r;
    assign cntValue   = cnt_r;
endmodule // tcc_core
`default_nettype wire

/* File: verilog/tcc_pkg.sv */
// Purpose: shared constants of the timer counter control block
// Assumes: 32-bit register port, byte addresses
// Notes:   all offsets are word aligned
`default_nettype none
package tcc_pkg;
    // register offsets
    localparam logic [7:0] TCC_OFS_CTRL   = 8'h00;
    localparam logic [7:0] TCC_OFS_RELOAD = 8'h80;
    localparam logic [7:0] TCC_OFS_PSC    = 8'h84;
    localparam logic [7:0] TCC_OFS_CMP0   = 8'h88;
    localparam logic [7:0] TCC_OFS_CNT    = 8'h98;
    localparam logic [7:0] TCC_OFS_STAT   = 8'h9C;
    localparam logic [7:0] TCC_OFS_MASK   = 8'hA0;
    localparam logic [7:0] TCC_OFS_EVGEN  = 8'hA4;
    // control field positions
    localparam int TCC_B_RUN   = 0;
    localparam int TCC_B_UDIS  = 1;
    localparam int TCC_B_USRC  = 2;
    localparam int TCC_B_ONE   = 3;
    localparam int TCC_B_DIR   = 4;
    localparam int TCC_B_ALN   = 5;
    localparam int TCC_B_ARBUF = 7;
    localparam int TCC_CTRL_W  = 8;
    // status and mask layout
    localparam int TCC_S_UPD   = 0;
    localparam int TCC_S_CMP   = 1;
    localparam int TCC_NCH     = 4;
    localparam int TCC_STAT_W  = 5;
    // event generate bit
    localparam int TCC_G_UPD   = 0;
    // widths and reset values
    localparam int TCC_VW      = 16;
    localparam logic [7:0]  TCC_CTRL_RST = 8'h00;
    localparam logic [15:0] TCC_VAL_RST  = 16'h0000;
    localparam logic [4:0]  TCC_STAT_RST = 5'h00;
    // alignment mode codes
    typedef enum logic [1:0] {
        TCC_ALN_EDGE = 2'b00,
        TCC_ALN_DOWN = 2'b01,
        TCC_ALN_UP   = 2'b10,
        TCC_ALN_BOTH = 2'b11
    } tcc_aln_t;
endpackage
`default_nettype wire

/* File: verilog/tcc_preload_reg.sv */
// Purpose: buffered value with an active copy loaded on update
// Assumes: one clock, asynchronous active-high reset
// Notes:   unbuffered writes go straight to the active copy
`timescale 1ns/1ps
`default_nettype none
module tcc_preload_reg
    import tcc_pkg::*;
(
    input  wire logic              ref_clk,  // kernel clock
    input  wire logic              rst,      // async reset
    input  wire logic              ce,       // clock enable
    input  wire logic              wrEn,     // software write
    input  wire logic [TCC_VW-1:0] wrData,   // written value
    input  wire logic              bufEn,    // buffering on
    input  wire logic              load,     // update event
    output logic      [TCC_VW-1:0] bufVal,   // buffered copy
    output logic      [TCC_VW-1:0] actVal    // active copy
);
    // buffered copy follows every write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bufVal <= TCC_VAL_RST;
        end else if (ce && wrEn) begin
            bufVal <= wrData;
        end
    end

    // active copy: immediate or at update
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            actVal <= TCC_VAL_RST;
        end else if (ce) begin
            if (wrEn && !bufEn) begin
                actVal <= wrData;          // [R12]
            end else if (load) begin
                actVal <= bufVal;          // [R3] [R12]
            end
        end
    end
endmodule // tcc_preload_reg
`default_nettype wire

/* File: verification/tcc_core_monitor.sv */
// Purpose: concurrent checks on the counter control ports
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   shadow copies follow software writes only
`timescale 1ns/1ps
`default_nettype none
module tcc_core_monitor
    import tcc_pkg::*;
(
    input wire logic              ref_clk,          // kernel clock
    input wire logic              rst,              // async reset
    input wire logic              ce,               // clock enable
    input wire logic [7:0]        addr,             // byte address
    input wire logic [31:0]       wrData,           // write data
    input wire logic              wrStb,            // write strobe
    input wire logic              rdStb,            // read strobe
    input wire logic [31:0]       rdData,           // read data
    input wire logic              trigStart,        // trigger start
    input wire logic              slaveUpdReq,      // slave update request
    input wire logic              updateEventPulse, // update pulse
    input wire logic              cntDown,          // direction
    input wire logic              cntRunning,       // run enable
    input wire logic [TCC_VW-1:0] reloadValue,      // active reload
    input wire logic [TCC_VW-1:0] pscValue          // active prescaler
);
    logic [7:0]        ctrlSh;  // last written control byte
    logic [TCC_VW-1:0] rlSh;    // last written reload
    logic [TCC_VW-1:0] pscSh;   // last written prescaler
    logic              ctrlWr;  // control write now
    logic              ugWr;    // generate bit written now
    assign ctrlWr = ce && wrStb && addr == TCC_OFS_CTRL;
    assign ugWr = ce && wrStb && addr == TCC_OFS_EVGEN && wrData[0];
    // shadow of what software wrote
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrlSh <= 8'h00;
            rlSh   <= 16'h0000;
            pscSh  <= 16'h0000;
        end else if (ce && wrStb) begin
            if (addr == TCC_OFS_CTRL) ctrlSh <= wrData[7:0];
            if (addr == TCC_OFS_RELOAD) rlSh <= wrData[15:0];
            if (addr == TCC_OFS_PSC) pscSh <= wrData[15:0];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_ctrl_rsvd_zero: assert property (
        ce && rdStb && addr == TCC_OFS_CTRL |=> rdData[31:8] == 24'h000000)
        else $error("control read shows reserved bits");
    a_trig_sets_run: assert property (ce && trigStart |=> cntRunning)
        else $error("trigger start did not set run");
    a_oneshot_stop: assert property (
        ce && updateEventPulse && ctrlSh[3] && !trigStart && !ctrlWr |=> !cntRunning)
        else $error("one-shot did not stop the counter");
    a_upd_disabled: assert property (ctrlSh[1] |-> !updateEventPulse)
        else $error("update while disabled");
    a_ug_updates: assert property (ugWr && ctrlSh[2:1] == 2'b00 |-> updateEventPulse)
        else $error("generate bit gave no update");
    a_slave_updates: assert property (
        ce && slaveUpdReq && ctrlSh[2:1] == 2'b00 |-> updateEventPulse)
        else $error("slave request gave no update");
    a_src_limit: assert property (ctrlSh[2] && !cntRunning |-> !updateEventPulse)
        else $error("update from a filtered source");
    a_update_load: assert property (
        ce && updateEventPulse && !(wrStb && (addr == TCC_OFS_RELOAD || addr == TCC_OFS_PSC))
        |=> reloadValue == rlSh && pscValue == pscSh) else $error("update did not load");
    a_unbuf_reload: assert property (
        ce && wrStb && addr == TCC_OFS_RELOAD && !ctrlSh[7] |=> reloadValue == $past(wrData[15:0]))
        else $error("unbuffered reload not immediate");
    a_dir_locked: assert property (
        ctrlWr && ctrlSh[6:5] != 2'b00 && wrData[6:5] != 2'b00 && !wrData[0] && !cntRunning
        && !trigStart |=> $stable(cntDown)) else $error("direction written in center mode");
endmodule // tcc_core_monitor
`default_nettype wire

/* File: verification/tcc_core_tb.sv */
// Purpose: register-level test of the counter control block
// Assumes: clock enable low only in one short freeze, prescaler set to zero early
// Notes:   every expectation follows the control bit map
`timescale 1ns/1ps
`default_nettype none
module tcc_core_tb
    import tcc_pkg::*;
;
    logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, wrStb = 1'b0, rdStb = 1'b0;
    logic trigStart = 1'b0, slaveUpdReq = 1'b0, encMode = 1'b0, encDir = 1'b0;
    logic [7:0]  addr   = 8'h00;
    logic [31:0] wrData = 32'h00000000;
    logic [31:0] rdData;
    logic updateEventPulse, cntDown, cntRunning, irq;
    logic [TCC_VW-1:0] cntValue, reloadValue, pscValue, cmpValue0, cmpValue1, cmpValue2, cmpValue3;
    logic [3:0] cmpSet = 4'hD;  // compare flag expected per alignment code
    int err_count = 0, total_checks = 0, i, n;
    // device under test
    tcc_core i_dut (.ref_clk, .rst, .ce, .addr, .wrData, .wrStb, .rdStb, .rdData,
        .trigStart, .slaveUpdReq, .encMode, .encDir, .updateEventPulse, .cntDown,
        .cntRunning, .cntValue, .reloadValue, .pscValue, .cmpValue0, .cmpValue1,
        .cmpValue2, .cmpValue3, .irq);
    // kernel clock, 8 ns
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic lim(input int k);
        if (k >= 60) begin
            err_count++;
            $display("BAD t=%0t wait ran out", $time);
            test_done();
        end
    endtask
    // one write cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr   <= a;
        wrData <= d;
        wrStb  <= 1'b1;
        @(posedge ref_clk);
        wrStb  <= 1'b0;
        #1;
    endtask
    // one read cycle, data compared in the following cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge ref_clk);
        addr  <= a;
        rdStb <= 1'b1;
        @(posedge ref_clk);
        rdStb <= 1'b0;
        #1;
        chk(rdData & m, e);
    endtask
    // one-cycle pulse on trigger start or slave request
    task automatic pulse(input bit trig);
        @(posedge ref_clk);
        if (trig) trigStart <= 1'b1;
        else slaveUpdReq <= 1'b1;
        @(posedge ref_clk);
        trigStart   <= 1'b0;
        slaveUpdReq <= 1'b0;
        #1;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rd(TCC_OFS_CTRL, 32'hFFFFFFFF, 32'h00000000);
        rd(8'h40, 32'hFFFFFFFF, 32'h00000000);
        wr(TCC_OFS_CTRL, 32'hFFFFFF90);
        rd(TCC_OFS_CTRL, 32'hFFFFFFFF, 32'h00000090);
        wr(TCC_OFS_RELOAD, 32'h00000010);
        chk(reloadValue, 32'h0);
        wr(TCC_OFS_PSC, 32'h0);
        wr(TCC_OFS_CMP0, 32'h00000005);
        wr(TCC_OFS_CMP0 + 8'h04, 32'h00000006);
        wr(TCC_OFS_CMP0 + 8'h08, 32'h00000007);
        wr(TCC_OFS_CMP0 + 8'h0C, 32'h00000009);
        chk(cmpValue3, 32'h0);
        wr(TCC_OFS_EVGEN, 32'h00000001);
        chk({reloadValue, cmpValue0}, 32'h00100005);
        chk({cmpValue1, cmpValue2}, 32'h00060007);
        chk(cmpValue3, 32'h00000009);
        rd(TCC_OFS_CMP0 + 8'h0C, 32'hFFFFFFFF, 32'h00000009);
        wr(TCC_OFS_CTRL, 32'h00000002);
        wr(TCC_OFS_PSC, 32'h00000003);
        wr(TCC_OFS_EVGEN, 32'h00000001);
        pulse(1'b0);
        chk(pscValue, 32'h0);
        wr(TCC_OFS_CTRL, 32'h00000004);
        wr(TCC_OFS_EVGEN, 32'h00000001);
        pulse(1'b0);
        chk(pscValue, 32'h0);
        wr(TCC_OFS_CTRL, 32'h00000000);
        pulse(1'b0);
        chk(pscValue, 32'h00000003);
        wr(TCC_OFS_PSC, 32'h0);
        wr(TCC_OFS_EVGEN, 32'h00000001);
        chk(pscValue, 32'h0);
        wr(TCC_OFS_RELOAD, 32'h00000004);
        chk(reloadValue, 32'h00000004);
        // one-shot run, then the update interrupt
        wr(TCC_OFS_STAT, 32'h0000001F);
        wr(TCC_OFS_MASK, 32'h00000001);
        wr(TCC_OFS_CTRL, 32'h00000009);
        for (n = 0; n < 60 && cntRunning !== 1'b0; n++) begin @(posedge ref_clk); #1; end
        lim(n);
        chk(cntValue, 32'h0);
        chk(irq, 32'h1);
        rd(TCC_OFS_STAT, 32'h00000001, 32'h00000001);
        wr(TCC_OFS_MASK, 32'h0);
        chk(irq, 32'h0);
        wr(TCC_OFS_MASK, 32'h00000001);
        wr(TCC_OFS_STAT, 32'h00000001);
        chk(irq, 32'h0);
        rd(TCC_OFS_STAT, 32'h00000001, 32'h0);
        pulse(1'b1);
        chk(cntRunning, 32'h1);
        // clock enable low freezes the running counter
        @(posedge ref_clk);
        ce <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(cntValue, 32'h00000001);
        @(posedge ref_clk);
        ce <= 1'b1;
        wr(TCC_OFS_CTRL, 32'h0);
        chk(cntRunning, 32'h0);
        // direction locked in center and encoder operation
        wr(TCC_OFS_CTRL, 32'h00000020);
        wr(TCC_OFS_CTRL, 32'h00000030);
        rd(TCC_OFS_CTRL, 32'hFFFFFFFF, 32'h00000020);
        wr(TCC_OFS_CTRL, 32'h0);
        encMode <= 1'b1;
        wr(TCC_OFS_CTRL, 32'h00000010);
        chk(cntDown, 32'h0);
        encMode <= 1'b0;
        // compare flag timing per alignment code
        wr(TCC_OFS_RELOAD, 32'h00000008);
        wr(TCC_OFS_CMP0, 32'h00000002);
        for (i = 0; i < 4; i++) begin
            wr(TCC_OFS_CTRL, {25'h0, i[1:0], 5'h00});
            wr(TCC_OFS_EVGEN, 32'h00000001);
            wr(TCC_OFS_STAT, 32'h0000001F);
            wr(TCC_OFS_CTRL, {25'h0, i[1:0], 5'h01});
            for (n = 0; n < 60 && cntValue !== 16'h0004; n++) begin @(posedge ref_clk); #1; end
            lim(n);
            wr(TCC_OFS_CTRL, {25'h0, i[1:0], 5'h00});
            rd(TCC_OFS_STAT, 32'h00000002, {30'h0, cmpSet[i], 1'b0});
        end
        wr(TCC_OFS_CTRL, 32'h00000061);
        for (n = 0; n < 60 && cntDown !== 1'b1; n++) begin @(posedge ref_clk); #1; end
        lim(n);
        wr(TCC_OFS_CTRL, 32'h00000060);
        // down-count compare flag in the first center code
        wr(TCC_OFS_CTRL, 32'h00000020);
        wr(TCC_OFS_STAT, 32'h0000001F);
        wr(TCC_OFS_CTRL, 32'h00000021);
        for (n = 0; n < 60 && cntValue !== 16'h0001; n++) begin @(posedge ref_clk); #1; end
        lim(n);
        wr(TCC_OFS_CTRL, 32'h00000020);
        rd(TCC_OFS_STAT, 32'h00000002, 32'h00000002);
        test_done();
    end
endmodule // tcc_core_tb
bind tcc_core tcc_core_monitor i_mon (.ref_clk, .rst, .ce, .addr, .wrData, .wrStb, .rdStb,
    .rdData, .trigStart, .slaveUpdReq, .updateEventPulse, .cntDown, .cntRunning,
    .reloadValue, .pscValue);
`default_nettype wire
